// file: inc/lsar_pkg.sv
`default_nettype none
package lsar_pkg;
  // Register indices; printed offsets are not multiples of four
  localparam logic [7:0] ATTR_IDX_FIRST = 8'h59;
  localparam logic [7:0] ATTR_IDX_LAST  = 8'h5f;
  localparam int         NUM_REGS       = 7;
  localparam int         NUM_SEGS       = 14;
  localparam logic [7:0] ATTR_RESET     = 8'h00;
  // Byte address is four times the index
  localparam logic [11:0] ATTR_ADDR_FIRST = {2'b00, ATTR_IDX_FIRST, 2'b00};
  // Nibble field layout
  localparam int BIT_RD = 0;
  localparam int BIT_WR = 1;
  localparam int BIT_CE = 2;
  // Region boundaries (20-bit legacy addresses)
  localparam logic [19:0] LEGACY_LO = 20'hc0000;
  localparam logic [19:0] SYSBIOS_LO = 20'hf0000;
  localparam int SEG_SHIFT = 14;
  // Latched status register byte address
  localparam logic [11:0] STATUS_ADDR = 12'h180;
  typedef enum logic [2:0] {
    LSAR_IDLE   = 3'b001,
    LSAR_ACCESS = 3'b010,
    LSAR_DONE   = 3'b100
  } lsar_apb_e;
endpackage : lsar_pkg
`default_nettype wire

// file: src/lsar_seg_decode.sv
`timescale 1ns/1ns
`default_nettype none
module lsar_seg_decode
  import lsar_pkg::*;
(
  // Address in
  input  wire logic [31:0] addr,
  // Decode out
  output logic             hit,
  output logic [3:0]       seg
);
  wire        below_1m   = (addr[31:20] == 12'h000);
  wire        in_range   = below_1m && (addr[19:0] >= LEGACY_LO);
  wire        is_sysbios = addr[19:0] >= SYSBIOS_LO;
  wire [3:0]  seg16k     = 4'(addr[19:SEG_SHIFT] - 6'h30);
  // Segment 0 is the system BIOS area; 16K segments count from 1
  assign hit = in_range;
  assign seg = is_sysbios ? 4'h0 : 4'(seg16k + 4'h1);
endmodule : lsar_seg_decode
`default_nettype wire

// file: src/lsar_route.sv
`timescale 1ns/1ns
`default_nettype none
module lsar_route
  import lsar_pkg::*;
(
  // Segment attributes
  input  wire logic [2:0] attr,
  input  wire logic       hit,
  // Cycle
  input  wire logic       is_write,
  input  wire logic       is_code,
  // Decisions
  output logic            to_dram,
  output logic            l1_ok,
  output logic            l2_ok
);
  wire rd = attr[BIT_RD];
  wire wr = attr[BIT_WR];
  wire ce = attr[BIT_CE];
  // Outside the legacy window main memory answers as normal
  assign to_dram = !hit || (is_write ? wr : rd);
  assign l1_ok   = !hit || (!is_write && rd && ce && (wr || is_code));
  // Read-only never enters L2
  assign l2_ok   = !hit || (to_dram && wr);
endmodule : lsar_route
`default_nettype wire

// file: src/lsar_top.sv
// Chosen here: the APB register port.
`timescale 1ns/1ns
`default_nettype none
module lsar_top
  import lsar_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Processor cycle
  input  wire logic        cpu_valid,
  input  wire logic [31:0] cpu_addr,
  input  wire logic        cpu_write,
  input  wire logic        cpu_code,
  output logic             cpu_to_dram,
  output logic             cpu_to_pci,
  output logic             cpu_l1_cacheable,
  output logic             cpu_l2_allocate,
  // PCI master cycle
  input  wire logic        pci_valid,
  input  wire logic [31:0] pci_addr,
  input  wire logic        pci_write,
  output logic             pci_claim
);
  import lsar_pkg::*;

  logic [1:0]      rst_sync_reg;
  wire             srst_n = rst_sync_reg[1];
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      rst_sync_reg <= 2'b00;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end

  logic [7:0]      attr_reg [NUM_REGS];
  lsar_apb_e       state_reg;
  lsar_apb_e       state_next;
  logic            pready_reg;
  logic [31:0]     prdata_reg;
  logic            pslverr_reg;
  logic [7:0]      route_status_reg;

  // Register index from byte address
  function automatic logic [2:0] reg_index(input logic [11:0] a);
    reg_index = 3'(a[11:2] - ATTR_ADDR_FIRST[11:2]);
  endfunction : reg_index

  function automatic logic in_attr_map(input logic [11:0] a);
    in_attr_map = (a[1:0] == 2'b00) && (a[11:2] >= ATTR_IDX_FIRST)
                  && (a[11:2] <= ATTR_IDX_LAST);
  endfunction : in_attr_map

  wire        acc_phase = psel && penable && (state_reg == LSAR_ACCESS);
  wire        attr_sel  = in_attr_map(paddr);
  wire        stat_sel  = (paddr == STATUS_ADDR);
  wire        map_sel   = attr_sel || stat_sel;
  wire [2:0]  ridx      = reg_index(paddr);
  wire        do_write  = acc_phase && pwrite && attr_sel && pstrb[0];
  wire [31:0] rd_value  = attr_sel ? {24'h000000, attr_reg[ridx]} :
                          stat_sel ? {24'h000000, route_status_reg} : 32'h00000000;

  // One wait state keeps pready registered and the answer fixed at two access edges
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      LSAR_IDLE:   if (psel && !penable) state_next = LSAR_ACCESS;
      LSAR_ACCESS: if (acc_phase) state_next = LSAR_DONE;
      LSAR_DONE:   state_next = LSAR_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge srst_n)
  begin
    if (!srst_n)
    begin
      state_reg   <= LSAR_IDLE;
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h00000000;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      state_reg   <= state_next;
      pready_reg  <= acc_phase;
      pslverr_reg <= acc_phase && !map_sel;
      if (acc_phase)
        prdata_reg <= pwrite ? 32'h00000000 : rd_value;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_REGS; gi++)
    begin : g_attr
      always_ff @(posedge ref_clk or negedge srst_n)
      begin
        if (!srst_n)
          attr_reg[gi] <= ATTR_RESET;
        else if (do_write && ridx == 3'(gi))
          attr_reg[gi] <= pwdata[7:0];
      end
    end
  endgenerate

  // Flatten nibbles: segment n lives in register (n+1)/2, nibble (n+1)%2
  logic [2:0] seg_attr [16];
  genvar si;
  generate
    for (si = 0; si < 16; si++)
    begin : g_seg
      if ((si + 1) / 2 < NUM_REGS)
      begin : g_on
        assign seg_attr[si] = attr_reg[(si + 1) / 2][((si + 1) % 2) * 4 +: 3];
      end
      else
      begin : g_off
        assign seg_attr[si] = 3'b000;
      end
    end
  endgenerate

  wire        cpu_hit;
  wire [3:0]  cpu_seg;
  wire        pci_hit;
  wire [3:0]  pci_seg;
  wire        cpu_dram_w;
  wire        cpu_l1_w;
  wire        cpu_l2_w;
  wire        pci_dram_w;

  lsar_seg_decode u_cpu_dec
  (
    .addr (cpu_addr),
    .hit  (cpu_hit),
    .seg  (cpu_seg)
  );

  lsar_seg_decode u_pci_dec
  (
    .addr (pci_addr),
    .hit  (pci_hit),
    .seg  (pci_seg)
  );

  lsar_route u_cpu_route
  (
    .attr     (seg_attr[cpu_seg]),
    .hit      (cpu_hit),
    .is_write (cpu_write),
    .is_code  (cpu_code),
    .to_dram  (cpu_dram_w),
    .l1_ok    (cpu_l1_w),
    .l2_ok    (cpu_l2_w)
  );

  lsar_route u_pci_route
  (
    .attr     (seg_attr[pci_seg]),
    .hit      (pci_hit),
    .is_write (pci_write),
    .is_code  (1'b0),
    .to_dram  (pci_dram_w),
    .l1_ok    (),
    .l2_ok    ()
  );

  // Registered decisions: outputs come from flops, one cycle after the request
  logic cpu_dram_reg;
  logic cpu_pci_reg;
  logic cpu_l1_reg;
  logic cpu_l2_reg;
  logic pci_claim_reg;
  always_ff @(posedge ref_clk or negedge srst_n)
  begin
    if (!srst_n)
    begin
      cpu_dram_reg     <= 1'b0;
      cpu_pci_reg      <= 1'b0;
      cpu_l1_reg       <= 1'b0;
      cpu_l2_reg       <= 1'b0;
      pci_claim_reg    <= 1'b0;
      route_status_reg <= 8'h00;
    end
    else
    begin
      cpu_dram_reg  <= cpu_valid && cpu_dram_w;
      cpu_pci_reg   <= cpu_valid && !cpu_dram_w;
      cpu_l1_reg    <= cpu_valid && cpu_l1_w;
      cpu_l2_reg    <= cpu_valid && cpu_l2_w;
      pci_claim_reg <= pci_valid && pci_dram_w;
      if (cpu_valid)
        route_status_reg <= {3'b000, cpu_hit, cpu_seg};
    end
  end

  assign pready           = pready_reg;
  assign prdata           = prdata_reg;
  assign pslverr          = pslverr_reg;
  assign cpu_to_dram      = cpu_dram_reg;
  assign cpu_to_pci       = cpu_pci_reg;
  assign cpu_l1_cacheable = cpu_l1_reg;
  assign cpu_l2_allocate  = cpu_l2_reg;
  assign pci_claim        = pci_claim_reg;

  a_ro_no_l2: assert property (@(posedge ref_clk) disable iff (!srst_n)
    cpu_valid && cpu_hit && !seg_attr[cpu_seg][BIT_WR] |=> !cpu_l2_allocate)
    else $error("read-only or disabled segment allocated in L2");
  a_wr_route: assert property (@(posedge ref_clk) disable iff (!srst_n)
    cpu_valid && cpu_hit && cpu_write |=>
    cpu_to_dram == $past(seg_attr[cpu_seg][BIT_WR]))
    else $error("write routing wrong");
  a_rd_route: assert property (@(posedge ref_clk) disable iff (!srst_n)
    cpu_valid && cpu_hit && !cpu_write |=>
    cpu_to_pci == !$past(seg_attr[cpu_seg][BIT_RD]))
    else $error("read routing wrong");
  a_l1_code: assert property (@(posedge ref_clk) disable iff (!srst_n)
    cpu_valid && cpu_hit && !cpu_code && !seg_attr[cpu_seg][BIT_WR] |=> !cpu_l1_cacheable)
    else $error("data read cached in write-protected segment");
  a_l1_set: assert property (@(posedge ref_clk) disable iff (!srst_n)
    cpu_valid && cpu_hit && !cpu_write && (&seg_attr[cpu_seg]) |=> cpu_l1_cacheable)
    else $error("cacheable segment not reported");
  a_pci_claim: assert property (@(posedge ref_clk) disable iff (!srst_n)
    pci_valid && pci_hit && !seg_attr[pci_seg][pci_write ? BIT_WR : BIT_RD] |=> !pci_claim)
    else $error("PCI cycle claimed without permission");
  a_excl_route: assert property (@(posedge ref_clk) disable iff (!srst_n)
    !(cpu_to_dram && cpu_to_pci))
    else $error("cycle routed to both memory and PCI");
  a_apb_ready: assert property (@(posedge ref_clk) disable iff (!srst_n)
    psel && !penable ##1 psel && penable |=> pready ##1 !pready)
    else $error("APB answer timing wrong");
  a_attr_write: assert property (@(posedge ref_clk) disable iff (!srst_n)
    do_write |=> attr_reg[$past(ridx)] == $past(pwdata[7:0]))
    else $error("attribute register not updated");
endmodule : lsar_top
`default_nettype wire

// file: testbench/lsar_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module lsar_host_model
(
  // Requests from the bench
  input  wire logic        ref_clk,
  input  wire logic        go,
  input  wire logic [31:0] a,
  input  wire logic        w,
  input  wire logic        c,
  input  wire logic        pw,
  // Processor and PCI master cycles
  output logic             cpu_valid,
  output logic [31:0]      cpu_addr,
  output logic             cpu_write,
  output logic             cpu_code,
  output logic             pci_valid,
  output logic [31:0]      pci_addr,
  output logic             pci_write
);
  // Idle buses show the inverse, so a stale address never decodes as a hit
  always_ff @(posedge ref_clk)
  begin
    cpu_valid <= go;
    pci_valid <= go;
    cpu_addr  <= go ? a : ~a;
    pci_addr  <= go ? a : ~a;
    cpu_write <= go ? w : ~w;
    cpu_code  <= go ? c : ~c;
    pci_write <= go ? pw : ~pw;
  end
endmodule : lsar_host_model
`default_nettype wire

// file: testbench/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  import lsar_pkg::*;
  logic        ref_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, a = 32'h0, cpu_addr, pci_addr, prdata, r;
  logic [3:0]  pstrb = 4'hf;
  logic        go = 1'b0, w = 1'b0, c = 1'b0, pw = 1'b0, v1 = 1'b0;
  logic        pready, pslverr, cpu_valid, cpu_write, cpu_code, pci_valid, pci_write;
  logic        cpu_to_dram, cpu_to_pci, cpu_l1_cacheable, cpu_l2_allocate, pci_claim;
  logic [7:0]  attr [NUM_REGS];
  logic [33:0] qa [$];
  logic [4:0]  qc [$];
  logic [31:0] rng = 32'd23;
  logic [3:0]  codes [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h7};
  int          failures = 0, checked = 0;

  always #50 ref_clk = ~ref_clk;

  lsar_top u_lsar_top (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .pready, .prdata, .pslverr, .cpu_valid, .cpu_addr, .cpu_write, .cpu_code, .cpu_to_dram,
    .cpu_to_pci, .cpu_l1_cacheable, .cpu_l2_allocate, .pci_valid, .pci_addr, .pci_write,
    .pci_claim);
  lsar_host_model u_lsar_host_model (.ref_clk, .go, .a, .w, .c, .pw, .cpu_valid, .cpu_addr,
    .cpu_write, .cpu_code, .pci_valid, .pci_addr, .pci_write);

  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : xs

  task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  // Expected routing worked out from the attribute shadow
  function automatic logic [4:0] expect_of(input logic [31:0] ad, input logic wr, cd, pwr);
    logic [3:0] n;
    logic       dr;
    int         i;
    if (ad < 32'hc0000 || ad > 32'hfffff)
      return 5'b10111;
    i = 1 + int'((ad - 32'hc0000) >> 15);
    n = (ad >= 32'hf0000) ? attr[0][7:4] : (ad[14] ? attr[i][7:4] : attr[i][3:0]);
    dr = wr ? n[1] : n[0];
    return {dr, !dr, !wr & n[0] & n[2] & (n[1] | cd), dr & n[1], pwr ? n[1] : n[0]};
  endfunction : expect_of

  task automatic apb(input logic wr, input logic [11:0] ad, input logic [7:0] d,
                     input logic err, input logic [3:0] st);
    r = xs();
    qa.push_back({~wr, err, wr ? 32'h0 : {24'h0, d}});
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pstrb <= st;
    pwdata <= {r[31:8], d};
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb

  task automatic cyc(input logic [31:0] ad, input logic wr, cd, pwr);
    qc.push_back(expect_of(ad, wr, cd, pwr));
    go <= 1'b1;
    a <= ad;
    w <= wr;
    c <= cd;
    pw <= pwr;
    @(posedge ref_clk);
  endtask : cyc

  task automatic set_all(input logic [7:0] v0, input logic [7:0] v1x);
    for (int i = 0; i < NUM_REGS; i++)
    begin
      attr[i] = (i % 2) ? v0 : v1x;
      apb(1'b1, ATTR_ADDR_FIRST + 12'(4 * i), attr[i], 1'b0, 4'hf);
    end
  endtask : set_all

  always @(posedge ref_clk)
    if (psel && penable && pready === 1'b1)
    begin
      cmp({qa[0][33], pslverr, qa[0][33] ? prdata : 32'h0}, qa[0]);
      qa.delete(0);
    end

  always @(posedge ref_clk) v1 <= cpu_valid;
  always @(negedge ref_clk)
    if (v1)
      cmp({29'h0, cpu_to_dram, cpu_to_pci, cpu_l1_cacheable, cpu_l2_allocate, pci_claim},
          {29'h0, qc.pop_front()});

  initial
  begin
    #(100 * 20000);
    failures++;
    tally_and_finish();
  end

  initial
  begin
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    for (int i = 0; i < NUM_REGS; i++)
      apb(1'b0, ATTR_ADDR_FIRST + 12'(4 * i), 8'h00, 1'b0, 4'hf);
    apb(1'b0, ATTR_ADDR_FIRST - 12'h004, 8'h00, 1'b1, 4'hf);
    apb(1'b1, ATTR_ADDR_FIRST + 12'h020, 8'h77, 1'b1, 4'hf);
    foreach (codes[k])
    begin
      r = xs();
      set_all({r[7], codes[k][2:0], r[3], codes[k][2:0]}, {r[3], codes[k][2:0], r[7], codes[k][2:0]});
      for (int b = 0; b < 17; b++)
        for (int m = 0; m < 4; m++)
          cyc(32'hc0000 + 32'(b) * 32'h4000 + {18'h0, r[13:0]}, m[0], m[1], m[0] ^ m[1]);
      go <= 1'b0;
      repeat (4) @(posedge ref_clk);
    end
    for (int k = 0; k < 4; k++)
    begin
      for (int i = 0; i < NUM_REGS; i++)
      begin
        r = xs();
        attr[i] = r[7:0] & ~{~r[4], 3'b000, ~r[0], 3'b000};
        apb(1'b1, ATTR_ADDR_FIRST + 12'(4 * i), attr[i], 1'b0, 4'hf);
        apb(1'b1, ATTR_ADDR_FIRST + 12'(4 * i), ~attr[i], 1'b0, 4'he);
        apb(1'b0, ATTR_ADDR_FIRST + 12'(4 * i), attr[i], 1'b0, 4'hf);
      end
      for (int n = 0; n < 100; n++)
      begin
        r = xs();
        cyc(32'hc0000 + 32'(r[4:0] % 17) * 32'h4000 + {18'h0, r[21:8]}, r[24], r[25], r[26]);
      end
      go <= 1'b0;
      repeat (4) @(posedge ref_clk);
    end
    // Status keeps hit and segment of the last processor cycle
    cyc(32'h000ec000, 1'b0, 1'b0, 1'b0);
    go <= 1'b0;
    repeat (4) @(posedge ref_clk);
    apb(1'b0, STATUS_ADDR, 8'h1c, 1'b0, 4'hf);
    // Mid-run reset must clear every attribute back to disabled
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    for (int i = 0; i < NUM_REGS; i++)
    begin
      attr[i] = ATTR_RESET;
      apb(1'b0, ATTR_ADDR_FIRST + 12'(4 * i), ATTR_RESET, 1'b0, 4'hf);
    end
    for (int b = 0; b < 16; b++)
      cyc(32'hc0000 + 32'(b) * 32'h4000, b[0], b[1], b[2]);
    go <= 1'b0;
    repeat (4) @(posedge ref_clk);
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
